/* psd_map.vh */
`ifndef PSD_MAP_VH
`define PSD_MAP_VH

////////////////////////////////////////////////////////////////
// register offsets on the plain register port
`define PSD_OFS_SRC_DRV0   4'h0
`define PSD_OFS_SRC_DRV1   4'h1
`define PSD_OFS_PA_FSEL0   4'h2
`define PSD_OFS_PA_FSEL1   4'h3
`define PSD_OFS_PB_FSEL0   4'h4
`define PSD_OFS_PB_FSEL1   4'h5
`define PSD_OFS_PC_FSEL0   4'h6
`define PSD_OFS_PC_FSEL1   4'h7
`define PSD_OFS_PD_FSEL0   4'h8
`define PSD_OFS_IN_ROUTE0  4'h9
`define PSD_OFS_IN_ROUTE1  4'hA

////////////////////////////////////////////////////////////////
// reset value and implemented-bit masks
`define PSD_RST_VAL        8'h00
`define PSD_MASK_FULL      8'hFF
`define PSD_MASK_SRC_DRV1  8'h3F
`define PSD_MASK_PC_FSEL1  8'h0F
`define PSD_MASK_IN_ROUTE1 8'h3F

////////////////////////////////////////////////////////////////
// drive-level field positions (lsb of each 2-bit field)
`define PSD_DRV_PA_LO_LSB  0
`define PSD_DRV_PA_HI_LSB  2
`define PSD_DRV_PB_LO_LSB  4
`define PSD_DRV_PB_HI_LSB  6
`define PSD_DRV_PC_LO_LSB  0
`define PSD_DRV_PC_HI_LSB  2
`define PSD_DRV_PD_LSB     4
`define PSD_FIELD_W        2

// level 0 is the weakest source current
`define PSD_DRV_LEVEL0     2'h0

`endif

/* psd_periph_model.sv */
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////
// peripherals and board pads on the far side of the mux
module psd_periph_model (
    input  wire logic   i_mclk,
    input  wire logic   i_en,
    input  wire logic   i_level,
    input  wire logic   i_claim,
    output logic [13:0] o_outs,
    output logic [4:0]  o_drvs,
    output logic [7:0]  o_pa_pin,
    output logic [7:0]  o_pb_pin
);
    // disabled units show the opposite level, so a stale route shows up
    always @(posedge i_mclk) begin
        o_outs <= i_en ? {14{i_level}} : {14{~i_level}};
        o_drvs <= {5{i_en & i_claim}};
        // pads show the opposite of the unit level, so the return path is seen
        o_pa_pin <= {8{~i_level}};
        o_pb_pin <= {8{~i_level}};
    end
endmodule // psd_periph_model

`default_nettype wire

/* psd_pin_mux.v */
`timescale 1ns/1ns
`include "psd_map.vh"
`default_nettype none

// one pad: 4-way function pick, drive level, input return
module psd_pin_mux (
    input  wire       i_mclk,
    input  wire       i_rst,
    input  wire [1:0] i_sel,
    input  wire [1:0] i_drive_sel,
    input  wire [3:0] i_cand_val,
    input  wire [3:0] i_cand_drv,
    input  wire [3:0] i_cand_ana,
    input  wire [3:0] i_cand_gpio,
    input  wire       i_pin_sync,
    output reg        o_do,
    output reg        o_oe_n,
    output reg  [1:0] o_drive,
    output reg        o_analog,
    output reg        o_gpio_in,
    output reg        o_func_in
);

    wire sel_val  = i_cand_val[i_sel];
    wire sel_ana  = i_cand_ana[i_sel];
    wire sel_gpio = i_cand_gpio[i_sel];
    // analog functions never get the digital driver
    wire sel_drv  = i_cand_drv[i_sel] & ~sel_ana;

    // registered so pad outputs never glitch on a field write
    always @(posedge i_mclk) begin
        if (i_rst) begin
            o_do      <= 1'b0;
            o_oe_n    <= 1'b1;
            o_drive   <= `PSD_DRV_LEVEL0;
            o_analog  <= 1'b0;
            o_gpio_in <= 1'b0;
            o_func_in <= 1'b0;
        end else begin
            o_do      <= sel_drv & sel_val;
            o_oe_n    <= ~sel_drv;
            // level only matters while the pad is a cmos output
            o_drive   <= sel_drv ? i_drive_sel : `PSD_DRV_LEVEL0;
            o_analog  <= sel_ana;
            o_gpio_in <= sel_gpio & i_pin_sync;
            o_func_in <= ~sel_gpio & ~sel_ana & i_pin_sync;
        end
    end

endmodule // psd_pin_mux

`default_nettype wire

/* psd_sync.v */
`timescale 1ns/1ns
`default_nettype none

// two-flop synchroniser for asynchronous pad levels
module psd_sync (
    input  wire        i_mclk,
    input  wire        i_rst,
    input  wire [15:0] i_async,
    output wire [15:0] o_sync
);

    reg [15:0] meta_reg;
    reg [15:0] sync_reg;

    // first stage feeds only the second stage
    always @(posedge i_mclk) begin
        if (i_rst) begin
            meta_reg <= 16'h0000;
            sync_reg <= 16'h0000;
        end else begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;

endmodule // psd_sync

`default_nettype wire

/* psd_top.v */
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`include "psd_map.vh"
`default_nettype none

module psd_top (
    input  wire       i_mclk,
    input  wire       i_rst,
    // register port
    input  wire [3:0] i_addr,
    input  wire [7:0] i_wdata,
    input  wire       i_wr,
    input  wire       i_rd,
    output reg  [7:0] o_rdata,
    // gpio data and direction (1 = input)
    input  wire [7:0] i_pa_data,
    input  wire [7:0] i_pa_dir_in,
    input  wire [7:0] i_pb_data,
    input  wire [7:0] i_pb_dir_in,
    // peripheral outputs toward the pads
    input  wire       i_spi_sdo,
    input  wire       i_spi_sdo_drv,
    input  wire       i_spi_sck,
    input  wire       i_spi_sck_drv,
    input  wire       i_spi_sda,
    input  wire       i_spi_sda_drv,
    input  wire       i_spi_chip_select,
    input  wire       i_spi_chip_select_drv,
    input  wire       i_uart0_transmit,
    input  wire       i_uart0_rxtx_drv,
    input  wire       i_per_timer0_out,
    input  wire       i_per_timer1_out,
    input  wire       i_per_timer2_out,
    input  wire       i_per_timer1_inverted_out,
    input  wire       i_per_timer2_inverted_out,
    input  wire       i_std_timer0_out,
    input  wire       i_std_timer0_inverted_out,
    input  wire       i_std_timer1_inverted_out,
    input  wire       i_powerline_transmit,
    // pad levels, asynchronous
    input  wire [7:0] i_pa_pin,
    input  wire [7:0] i_pb_pin,
    // pad drive
    output wire [7:0]  o_pa_do,
    output wire [7:0]  o_pa_oe_n,
    output wire [15:0] o_pa_drive,
    output wire [7:0]  o_pa_analog,
    output wire [7:0]  o_pb_do,
    output wire [7:0]  o_pb_oe_n,
    output wire [15:0] o_pb_drive,
    output wire [7:0]  o_pb_analog,
    // pad levels returned to gpio and to peripherals
    output wire [7:0]  o_pa_gpio_in,
    output wire [7:0]  o_pa_func_in,
    output wire [7:0]  o_pb_gpio_in,
    output wire [7:0]  o_pb_func_in,
    // fields decoded by the port C/D and input-route logic
    output wire [1:0]  o_pc_lo_drive,
    output wire [1:0]  o_pc_hi_drive,
    output wire [1:0]  o_pd_drive,
    output wire [7:0]  o_portc_function_sel_0,
    output wire [7:0]  o_portc_function_sel_1,
    output wire [7:0]  o_portd_function_sel_0,
    output wire [7:0]  o_input_route_sel_0,
    output wire [7:0]  o_input_route_sel_1
);

    ////////////////////////////////////////////////////////////////
    // register file

    reg [7:0] src_drv0_reg;
    reg [7:0] src_drv1_reg;
    reg [7:0] pa_fsel0_reg;
    reg [7:0] pa_fsel1_reg;
    reg [7:0] pb_fsel0_reg;
    reg [7:0] pb_fsel1_reg;
    reg [7:0] pc_fsel0_reg;
    reg [7:0] pc_fsel1_reg;
    reg [7:0] pd_fsel0_reg;
    reg [7:0] in_route0_reg;
    reg [7:0] in_route1_reg;
    reg [7:0] rdata_next;

    // writes; unimplemented bits are never stored
    always @(posedge i_mclk) begin
        if (i_rst) begin
            src_drv0_reg  <= `PSD_RST_VAL;
            src_drv1_reg  <= `PSD_RST_VAL;
            pa_fsel0_reg  <= `PSD_RST_VAL;
            pa_fsel1_reg  <= `PSD_RST_VAL;
            pb_fsel0_reg  <= `PSD_RST_VAL;
            pb_fsel1_reg  <= `PSD_RST_VAL;
            pc_fsel0_reg  <= `PSD_RST_VAL;
            pc_fsel1_reg  <= `PSD_RST_VAL;
            pd_fsel0_reg  <= `PSD_RST_VAL;
            in_route0_reg <= `PSD_RST_VAL;
            in_route1_reg <= `PSD_RST_VAL;
        end else if (i_wr) begin
            case (i_addr)
                `PSD_OFS_SRC_DRV0: begin
                    src_drv0_reg <= i_wdata;
                end
                `PSD_OFS_SRC_DRV1: begin
                    src_drv1_reg <= i_wdata & `PSD_MASK_SRC_DRV1;
                end
                `PSD_OFS_PA_FSEL0: begin
                    pa_fsel0_reg <= i_wdata;
                end
                `PSD_OFS_PA_FSEL1: begin
                    pa_fsel1_reg <= i_wdata;
                end
                `PSD_OFS_PB_FSEL0: begin
                    pb_fsel0_reg <= i_wdata;
                end
                `PSD_OFS_PB_FSEL1: begin
                    pb_fsel1_reg <= i_wdata;
                end
                `PSD_OFS_PC_FSEL0: begin
                    pc_fsel0_reg <= i_wdata;
                end
                `PSD_OFS_PC_FSEL1: begin
                    pc_fsel1_reg <= i_wdata & `PSD_MASK_PC_FSEL1;
                end
                `PSD_OFS_PD_FSEL0: begin
                    pd_fsel0_reg <= i_wdata;
                end
                `PSD_OFS_IN_ROUTE0: begin
                    in_route0_reg <= i_wdata;
                end
                `PSD_OFS_IN_ROUTE1: begin
                    in_route1_reg <= i_wdata & `PSD_MASK_IN_ROUTE1;
                end
                default: begin
                    // unmapped write is dropped
                end
            endcase
        end
    end

    // read select; unmapped offsets read zero
    always @* begin
        case (i_addr)
            `PSD_OFS_SRC_DRV0:  rdata_next = src_drv0_reg;
            `PSD_OFS_SRC_DRV1:  rdata_next = src_drv1_reg;
            `PSD_OFS_PA_FSEL0:  rdata_next = pa_fsel0_reg;
            `PSD_OFS_PA_FSEL1:  rdata_next = pa_fsel1_reg;
            `PSD_OFS_PB_FSEL0:  rdata_next = pb_fsel0_reg;
            `PSD_OFS_PB_FSEL1:  rdata_next = pb_fsel1_reg;
            `PSD_OFS_PC_FSEL0:  rdata_next = pc_fsel0_reg;
            `PSD_OFS_PC_FSEL1:  rdata_next = pc_fsel1_reg;
            `PSD_OFS_PD_FSEL0:  rdata_next = pd_fsel0_reg;
            `PSD_OFS_IN_ROUTE0: rdata_next = in_route0_reg;
            `PSD_OFS_IN_ROUTE1: rdata_next = in_route1_reg;
            default:            rdata_next = `PSD_RST_VAL;
        endcase
    end

    // read data stands one cycle only, zero otherwise
    always @(posedge i_mclk) begin
        if (i_rst) begin
            o_rdata <= `PSD_RST_VAL;
        end else if (i_rd) begin
            o_rdata <= rdata_next;
        end else begin
            o_rdata <= `PSD_RST_VAL;
        end
    end

    ////////////////////////////////////////////////////////////////
    // port C/D and input-route fields go straight out

    assign o_pc_lo_drive = src_drv1_reg[`PSD_DRV_PC_LO_LSB +: `PSD_FIELD_W];
    assign o_pc_hi_drive = src_drv1_reg[`PSD_DRV_PC_HI_LSB +: `PSD_FIELD_W];
    assign o_pd_drive    = src_drv1_reg[`PSD_DRV_PD_LSB +: `PSD_FIELD_W];
    assign o_portc_function_sel_0 = pc_fsel0_reg;
    assign o_portc_function_sel_1 = pc_fsel1_reg;
    assign o_portd_function_sel_0 = pd_fsel0_reg;
    assign o_input_route_sel_0    = in_route0_reg;
    assign o_input_route_sel_1    = in_route1_reg;

    ////////////////////////////////////////////////////////////////
    // pad input synchroniser, ports A and B

    wire [15:0] pin_sync;

    psd_sync u_sync (
        .i_mclk  (i_mclk),
        .i_rst   (i_rst),
        .i_async ({i_pb_pin, i_pa_pin}),
        .o_sync  (pin_sync)
    );

    ////////////////////////////////////////////////////////////////
    // candidate tables, pin k at [4k+:4], codes {11,10,01,00}

    wire [15:0] g_val = {i_pb_data, i_pa_data};
    wire [15:0] g_drv = ~{i_pb_dir_in, i_pa_dir_in};
    wire [63:0] c_val;
    wire [63:0] c_drv;
    wire [63:0] c_ana;
    wire [63:0] c_gpio;

    // PA0
    assign c_val[3:0]   = {g_val[0], i_per_timer1_inverted_out, i_spi_sck, g_val[0]};
    assign c_drv[3:0]   = {g_drv[0], 1'b1, i_spi_sck_drv, g_drv[0]};
    assign c_ana[3:0]   = 4'h0;
    assign c_gpio[3:0]  = 4'h9;
    // PA1
    assign c_val[7:4]   = {2'h0, i_spi_chip_select, g_val[1]};
    assign c_drv[7:4]   = {2'h0, i_spi_chip_select_drv, g_drv[1]};
    assign c_ana[7:4]   = 4'hC;
    assign c_gpio[7:4]  = 4'h1;
    // PA2
    assign c_val[11:8]  = {i_per_timer2_inverted_out, i_uart0_transmit, i_spi_sda, g_val[2]};
    assign c_drv[11:8]  = {1'b1, i_uart0_rxtx_drv, i_spi_sda_drv, g_drv[2]};
    assign c_ana[11:8]  = 4'h0;
    assign c_gpio[11:8] = 4'h1;
    // PA3
    assign c_val[15:12] = {1'b0, i_uart0_transmit, i_spi_sdo, g_val[3]};
    assign c_drv[15:12] = {1'b0, 1'b1, i_spi_sdo_drv, g_drv[3]};
    assign c_ana[15:12] = 4'h8;
    assign c_gpio[15:12] = 4'h1;
    // PA4
    assign c_val[19:16] = {2'h0, i_std_timer0_inverted_out, g_val[4]};
    assign c_drv[19:16] = {2'h0, 1'b1, g_drv[4]};
    assign c_ana[19:16] = 4'hC;
    assign c_gpio[19:16] = 4'h1;
    // PA5
    assign c_val[23:20] = {g_val[5], 1'b0, i_std_timer1_inverted_out, g_val[5]};
    assign c_drv[23:20] = {g_drv[5], 1'b0, 1'b1, g_drv[5]};
    assign c_ana[23:20] = 4'h4;
    assign c_gpio[23:20] = 4'h9;
    // PA6
    assign c_val[27:24] = {i_uart0_transmit, i_spi_sda, i_per_timer0_out, g_val[6]};
    assign c_drv[27:24] = {i_uart0_rxtx_drv, i_spi_sda_drv, 1'b1, g_drv[6]};
    assign c_ana[27:24] = 4'h0;
    assign c_gpio[27:24] = 4'h1;
    // PA7
    assign c_val[31:28] = {2'h0, i_spi_sck, g_val[7]};
    assign c_drv[31:28] = {2'h0, i_spi_sck_drv, g_drv[7]};
    assign c_ana[31:28] = 4'hC;
    assign c_gpio[31:28] = 4'h1;
    // PB0
    assign c_val[35:32] = {2'h0, i_std_timer0_out, g_val[8]};
    assign c_drv[35:32] = {2'h0, 1'b1, g_drv[8]};
    assign c_ana[35:32] = 4'hC;
    assign c_gpio[35:32] = 4'h1;
    // PB1
    assign c_val[39:36] = {i_uart0_transmit, i_spi_sdo, i_powerline_transmit, g_val[9]};
    assign c_drv[39:36] = {1'b1, i_spi_sdo_drv, 1'b1, g_drv[9]};
    assign c_ana[39:36] = 4'h0;
    assign c_gpio[39:36] = 4'h1;
    // PB2
    assign c_val[43:40] = {1'b0, i_spi_sck, 1'b0, g_val[10]};
    assign c_drv[43:40] = {1'b0, i_spi_sck_drv, 1'b0, g_drv[10]};
    assign c_ana[43:40] = 4'hA;
    assign c_gpio[43:40] = 4'h1;
    // PB3 receive enters the powerline comparator
    assign c_val[47:44] = {i_uart0_transmit, i_spi_sda, 1'b0, g_val[11]};
    assign c_drv[47:44] = {i_uart0_rxtx_drv, i_spi_sda_drv, 1'b0, g_drv[11]};
    assign c_ana[47:44] = 4'h2;
    assign c_gpio[47:44] = 4'h1;
    // PB4
    assign c_val[51:48] = {2'h0, i_spi_chip_select, g_val[12]};
    assign c_drv[51:48] = {2'h0, i_spi_chip_select_drv, g_drv[12]};
    assign c_ana[51:48] = 4'hC;
    assign c_gpio[51:48] = 4'h1;
    // PB5
    assign c_val[55:52] = {1'b0, i_std_timer0_inverted_out, i_uart0_transmit, g_val[13]};
    assign c_drv[55:52] = {1'b0, 1'b1, 1'b1, g_drv[13]};
    assign c_ana[55:52] = 4'h8;
    assign c_gpio[55:52] = 4'h1;
    // PB6
    assign c_val[59:56] = {i_per_timer2_out, 2'h0, g_val[14]};
    assign c_drv[59:56] = {1'b1, 2'h0, g_drv[14]};
    assign c_ana[59:56] = 4'h6;
    assign c_gpio[59:56] = 4'h1;
    // PB7
    assign c_val[63:60] = {i_per_timer1_out, 1'b0, i_spi_chip_select, g_val[15]};
    assign c_drv[63:60] = {1'b1, 1'b0, i_spi_chip_select_drv, g_drv[15]};
    assign c_ana[63:60] = 4'h4;
    assign c_gpio[63:60] = 4'h1;

    ////////////////////////////////////////////////////////////////
    // one mux per pad; function fields sit in pin order

    // pin k field is fsel_all[2k+:2], drive group is k/4
    wire [31:0] fsel_all = {pb_fsel1_reg, pb_fsel0_reg, pa_fsel1_reg, pa_fsel0_reg};
    wire [15:0] do_w;
    wire [15:0] oe_n_w;
    wire [31:0] drive_w;
    wire [15:0] ana_w;
    wire [15:0] gin_w;
    wire [15:0] fin_w;

    genvar k;
    generate
        for (k = 0; k < 16; k = k + 1) begin : g_pad
            psd_pin_mux u_mux (
                .i_mclk      (i_mclk),
                .i_rst       (i_rst),
                .i_sel       (fsel_all[2*k +: 2]),
                .i_drive_sel (src_drv0_reg[2*(k/4) +: 2]),
                .i_cand_val  (c_val[4*k +: 4]),
                .i_cand_drv  (c_drv[4*k +: 4]),
                .i_cand_ana  (c_ana[4*k +: 4]),
                .i_cand_gpio (c_gpio[4*k +: 4]),
                .i_pin_sync  (pin_sync[k]),
                .o_do        (do_w[k]),
                .o_oe_n      (oe_n_w[k]),
                .o_drive     (drive_w[2*k +: 2]),
                .o_analog    (ana_w[k]),
                .o_gpio_in   (gin_w[k]),
                .o_func_in   (fin_w[k])
            );
        end
    endgenerate

    // pad outputs are the mux flip-flops
    assign o_pa_do      = do_w[7:0];
    assign o_pb_do      = do_w[15:8];
    assign o_pa_oe_n    = oe_n_w[7:0];
    assign o_pb_oe_n    = oe_n_w[15:8];
    assign o_pa_drive   = drive_w[15:0];
    assign o_pb_drive   = drive_w[31:16];
    assign o_pa_analog  = ana_w[7:0];
    assign o_pb_analog  = ana_w[15:8];
    // shared digital inputs rely on the function select, not the direction bit
    assign o_pa_gpio_in = gin_w[7:0];
    assign o_pb_gpio_in = gin_w[15:8];
    assign o_pa_func_in = fin_w[7:0];
    assign o_pb_func_in = fin_w[15:8];

endmodule // psd_top

`default_nettype wire

/* psd_top_assertions.sv */
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////
// port-level checks on register reads and pad drive
module psd_top_checker (
    input wire logic        i_mclk,
    input wire logic        i_rst,
    input wire logic [3:0]  i_addr,
    input wire logic [7:0]  i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [7:0]  o_rdata,
    input wire logic [7:0]  o_pa_oe_n,
    input wire logic [15:0] o_pa_drive,
    input wire logic [7:0]  o_pa_analog,
    input wire logic [7:0]  o_pb_oe_n,
    input wire logic [15:0] o_pb_drive,
    input wire logic [7:0]  o_pb_analog,
    input wire logic [7:0]  o_pa_gpio_in,
    input wire logic [7:0]  o_pa_func_in,
    input wire logic [1:0]  o_pd_drive
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    // two drive bits per pin, so widen the enable to match
    function automatic logic [15:0] spread(input logic [7:0] v);
        for (int k = 0; k < 8; k++) spread[2*k +: 2] = {2{v[k]}};
    endfunction

    ////////////////////////////////////////////////////////////
    chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not zero outside read slot");
    chk_unmapped_zero: assert property ($past(i_rd) && $past(i_addr) > 4'hA |-> o_rdata == 8'h00)
        else $error("unmapped offset read not zero");
    chk_drv1_upper: assert property ($past(i_rd) && $past(i_addr) == 4'h1 |-> o_rdata[7:6] == 2'h0)
        else $error("unimplemented drive bits read nonzero");
    chk_drive_gated: assert property ((o_pa_drive & spread(o_pa_oe_n)) == 16'h0
        && (o_pb_drive & spread(o_pb_oe_n)) == 16'h0)
        else $error("drive level on a pad that is not driven");
    chk_analog_off: assert property ((o_pa_analog & ~o_pa_oe_n) == 8'h00
        && (o_pb_analog & ~o_pb_oe_n) == 8'h00)
        else $error("analog pad with digital driver on");
    chk_pa3_analog: assert property (i_wr && i_addr == 4'h2 && i_wdata[7:6] == 2'h3
        |-> ##2 o_pa_analog[3])
        else $error("analog code did not reach pad");
    chk_pa0_level: assert property (i_wr && i_addr == 4'h0
        |-> ##2 (o_pa_oe_n[0] || o_pa_drive[1:0] == $past(i_wdata[1:0], 2)))
        else $error("low port a drive level wrong");
    chk_pb7_level: assert property (i_wr && i_addr == 4'h0
        |-> ##2 (o_pb_oe_n[7] || o_pb_drive[15:14] == $past(i_wdata[7:6], 2)))
        else $error("high port b drive level wrong");
    chk_pd_field: assert property (i_wr && i_addr == 4'h1 |=> o_pd_drive == $past(i_wdata[5:4]))
        else $error("port d drive field wrong");
    chk_return_excl: assert property ((o_pa_gpio_in & o_pa_func_in) == 8'h00)
        else $error("pad level returned on both paths");

    // main scenarios reached
    cover property (i_wr && i_addr == 4'h2);
    cover property ($past(i_rd) && o_rdata != 8'h00);
    cover property (o_pb_analog != 8'h00);
endmodule // psd_top_checker

bind psd_top psd_top_checker psd_top_checker_inst (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_pa_oe_n(o_pa_oe_n), .o_pa_drive(o_pa_drive),
    .o_pa_analog(o_pa_analog), .o_pb_oe_n(o_pb_oe_n), .o_pb_drive(o_pb_drive),
    .o_pb_analog(o_pb_analog), .o_pa_gpio_in(o_pa_gpio_in), .o_pa_func_in(o_pa_func_in),
    .o_pd_drive(o_pd_drive)
);

`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ns
`default_nettype none

module testbench;
    logic        i_mclk = 1'b0;
    logic        i_rst = 1'b1;
    logic [3:0]  i_addr = 4'h0;
    logic [7:0]  i_wdata = 8'h00;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic [7:0]  i_pa_data = 8'h00;
    logic [7:0]  i_pb_data = 8'h00;
    logic [7:0]  i_pa_dir_in = 8'hFF;
    logic [7:0]  i_pb_dir_in = 8'hFF;
    logic        en = 1'b0;
    logic        level = 1'b0;
    logic        claim = 1'b0;
    wire  [7:0]  o_rdata, o_pa_do, o_pa_oe_n, o_pa_analog, o_pb_do, o_pb_oe_n, o_pb_analog;
    wire  [7:0]  o_pa_gpio_in, o_pa_func_in, o_pb_gpio_in, o_pb_func_in;
    wire  [15:0] o_pa_drive, o_pb_drive;
    wire  [1:0]  o_pc_lo_drive, o_pc_hi_drive, o_pd_drive;
    wire  [7:0]  portc_function_sel_0, portc_function_sel_1, portd_function_sel_0, irs0, irs1, pa_pin, pb_pin;
    wire  [13:0] outs;
    wire  [4:0]  drvs;
    int          failures = 0;
    int          total_checks = 0;
    // per pin, two bits per code: 0 gpio, 1 always driven, 2 peripheral claimed, 3 analog
    logic [7:0]  cls_tab [16] = '{8'h18, 8'hF8, 8'h68, 8'hD8, 8'hF4, 8'h34, 8'hA4, 8'hF8,
                                  8'hF4, 8'h64, 8'hEC, 8'hAC, 8'hF8, 8'hD4, 8'h7C, 8'h78};
    // offset, write value, value read back
    logic [23:0] rows [13] = '{24'h00A5A5, 24'h01FF3F, 24'h025A5A, 24'h03C3C3, 24'h043C3C,
                               24'h059696, 24'h066969, 24'h07FF0F, 24'h088181, 24'h097E7E,
                               24'h0AFF3F, 24'h0BFF00, 24'h0F1200};

    always #4 i_mclk = ~i_mclk;

    psd_top psd_top_inst (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_pa_data(i_pa_data), .i_pa_dir_in(i_pa_dir_in),
        .i_pb_data(i_pb_data), .i_pb_dir_in(i_pb_dir_in), .i_spi_sdo(outs[0]),
        .i_spi_sdo_drv(drvs[0]), .i_spi_sck(outs[1]), .i_spi_sck_drv(drvs[1]),
        .i_spi_sda(outs[2]), .i_spi_sda_drv(drvs[2]), .i_spi_chip_select(outs[3]),
        .i_spi_chip_select_drv(drvs[3]), .i_uart0_transmit(outs[4]),
        .i_uart0_rxtx_drv(drvs[4]), .i_per_timer0_out(outs[5]), .i_per_timer1_out(outs[6]),
        .i_per_timer2_out(outs[7]), .i_per_timer1_inverted_out(outs[8]),
        .i_per_timer2_inverted_out(outs[9]), .i_std_timer0_out(outs[10]),
        .i_std_timer0_inverted_out(outs[11]), .i_std_timer1_inverted_out(outs[12]),
        .i_powerline_transmit(outs[13]), .i_pa_pin(pa_pin), .i_pb_pin(pb_pin),
        .o_pa_do(o_pa_do), .o_pa_oe_n(o_pa_oe_n), .o_pa_drive(o_pa_drive),
        .o_pa_analog(o_pa_analog), .o_pb_do(o_pb_do), .o_pb_oe_n(o_pb_oe_n),
        .o_pb_drive(o_pb_drive), .o_pb_analog(o_pb_analog), .o_pa_gpio_in(o_pa_gpio_in),
        .o_pa_func_in(o_pa_func_in), .o_pb_gpio_in(o_pb_gpio_in), .o_pb_func_in(o_pb_func_in),
        .o_pc_lo_drive(o_pc_lo_drive), .o_pc_hi_drive(o_pc_hi_drive), .o_pd_drive(o_pd_drive),
        .o_portc_function_sel_0(portc_function_sel_0), .o_portc_function_sel_1(portc_function_sel_1),
        .o_portd_function_sel_0(portd_function_sel_0), .o_input_route_sel_0(irs0), .o_input_route_sel_1(irs1)
    );

    psd_periph_model psd_periph_model_inst (
        .i_mclk(i_mclk), .i_en(en), .i_level(level), .i_claim(claim),
        .o_outs(outs), .o_drvs(drvs), .o_pa_pin(pa_pin), .o_pb_pin(pb_pin)
    );

    ////////////////////////////////////////////////////////////
    task automatic close_out();
        if (failures == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic cmp_pad(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
        cmp_pad({8'h00, got}, {8'h00, exp});
    endtask

    // bus cycles start just after a rising edge
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
        @(posedge i_mclk);
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        @(negedge i_mclk);
        d = o_rdata;
        @(posedge i_mclk);
    endtask

    // select one code on one pin, re-enable peripherals, compare the pad
    task automatic pad_case(input int pin, input int code);
        logic [1:0] cls;
        logic [1:0] lvl;
        logic       do_e;
        logic       oe_e;
        logic [7:0] got;
        logic [7:0] exp;
        int         n;
        n = pin % 8;
        cls = cls_tab[pin][2*code +: 2];
        lvl = 2'(pin / 4);
        en <= 1'b0;
        @(posedge i_mclk);
        wr(4'h2 + 4'(pin / 4), 8'(code << (2 * (pin % 4))));
        en <= 1'b1;
        repeat (4) @(posedge i_mclk);
        @(negedge i_mclk);
        do_e = (cls == 2'h0) ? i_pa_data[0] : (cls == 2'h1 || (cls == 2'h2 && claim)) ? level : 1'b0;
        oe_e = (cls == 2'h3) || (cls == 2'h2 && !claim);
        exp = {1'b0, do_e, oe_e, cls == 2'h3, cls == 2'h0 && !level,
               (cls == 2'h1 || cls == 2'h2) && !level, oe_e ? 2'h0 : lvl};
        got = (pin < 8) ? {1'b0, o_pa_do[n], o_pa_oe_n[n], o_pa_analog[n], o_pa_gpio_in[n],
                           o_pa_func_in[n], o_pa_drive[2*n +: 2]}
                        : {1'b0, o_pb_do[n], o_pb_oe_n[n], o_pb_analog[n], o_pb_gpio_in[n],
                           o_pb_func_in[n], o_pb_drive[2*n +: 2]};
        cmp_pad({8'h00, got}, {8'h00, exp});
        @(posedge i_mclk);
    endtask

    ////////////////////////////////////////////////////////////
    // watchdog well beyond the expected run of about 1150 cycles
    initial begin
        #(20000 * 8);
        failures++;
        close_out();
    end

    initial begin
        logic [7:0] v;
        repeat (19) @(posedge i_mclk);
        @(negedge i_mclk);
        cmp_pad({o_pa_oe_n, o_pb_oe_n}, 16'hFFFF);
        @(posedge i_mclk);
        i_rst <= 1'b0;
        repeat (2) @(posedge i_mclk);
        foreach (rows[k]) begin
            rd(rows[k][19:16], v);
            cmp_reg(v, 8'h00);
        end
        foreach (rows[k]) wr(rows[k][19:16], rows[k][15:8]);
        foreach (rows[k]) begin
            rd(rows[k][19:16], v);
            cmp_reg(v, rows[k][7:0]);
        end
        cmp_pad({o_pc_lo_drive, o_pc_hi_drive, o_pd_drive, 2'h0, portc_function_sel_0}, 16'hFC69);
        cmp_pad({portc_function_sel_1, portd_function_sel_0}, 16'h0F81);
        cmp_pad({irs0, irs1}, 16'h7E3F);
        // write then read with no gap between strobes
        i_wr <= 1'b1;
        i_addr <= 4'h1;
        i_wdata <= 8'hC6;
        @(posedge i_mclk);
        i_wr <= 1'b0;
        rd(4'h1, v);
        cmp_reg(v, 8'h06);
        wr(4'h0, 8'hE4);
        i_pa_dir_in <= 8'h00;
        i_pb_dir_in <= 8'h00;
        for (int ps = 0; ps < 2; ps++) begin
            i_pa_data <= {8{ps == 0}};
            i_pb_data <= {8{ps == 0}};
            level <= (ps != 0);
            claim <= (ps != 0);
            for (int pin = 0; pin < 16; pin++)
                for (int code = 0; code < 4; code++) pad_case(pin, code);
        end
        // reset in mid-run clears every selection
        i_rst <= 1'b1;
        repeat (2) @(posedge i_mclk);
        @(negedge i_mclk);
        cmp_pad({o_pa_do, o_pb_analog}, 16'h0000);
        @(posedge i_mclk);
        i_rst <= 1'b0;
        repeat (2) @(posedge i_mclk);
        rd(4'h2, v);
        cmp_reg(v, 8'h00);
        wr(4'h0, 8'hFF);
        repeat (2) @(posedge i_mclk);
        @(negedge i_mclk);
        cmp_pad(o_pa_drive & o_pb_drive, 16'hFFFF);
        @(posedge i_mclk);
        i_pa_dir_in <= 8'hFF;
        i_pb_dir_in <= 8'hFF;
        repeat (2) @(posedge i_mclk);
        @(negedge i_mclk);
        cmp_pad(o_pa_drive | o_pb_drive, 16'h0000);
        cmp_pad({o_pa_oe_n, o_pb_oe_n}, 16'hFFFF);
        close_out();
    end
endmodule // testbench

`default_nettype wire
